// file: logic/spsc_pkg.sv
// Constants and types for the serial-programmed PLL synthesizer core.
// Assumes all pins are sampled on core_clk; edges are found by comparing samples.
// Functional notes
// - Reference counter of 14 bits divides the oscillator input.
// - Main divider is a 7-bit swallow counter plus 10-bit counter.
// - One shared 18-bit shift register feeds a 14-bit and a 17-bit latch.
// - One data bit is captured on each rising shift clock edge.
// - Control bit high loads reference latch, low loads main latch.
// - While load enable is high, shift contents copy to selected latch.
// - Pump drives high, floats, or sinks by frequency comparison.
// - Lock output high when locked, otherwise low-going pulses.
// - Modulus control changes only on falling divider clock edges.
// - Modulus control high selects lower modulus, low the higher.
// - Divided VCO monitor reproduces main divider output.
// - Detector drives on-chip pump and external pump signals together.
// - First seven data bits set swallow count, next ten main count.
package spsc_pkg;
   localparam int REF_W = 14;
   localparam int SWL_W = 7;
   localparam int MAIN_W = 10;
   localparam int MAINWORD_W = SWL_W + MAIN_W;
   localparam int SHIFT_W = MAINWORD_W + 1;
   localparam logic [REF_W-1:0] REF_RESET = 14'h0005;
   localparam logic [SWL_W-1:0] SWL_RESET = 7'h00;
   localparam logic [MAIN_W-1:0] MAIN_RESET = 10'h005;
   localparam int LOCK_PULSE_CYC = 1;
   // Serial link pin samples
   typedef struct packed {
      logic data;
      logic sclk;
      logic load_en;
   } spsc_serial_t;
   // Phase detector outputs
   typedef struct packed {
      logic pump_up_n;
      logic pump_down;
   } spsc_pump_t;
endpackage

// file: logic/spsc_core.sv
// Serial PLL synthesizer digital core: serial load, dividers, detector, modulus control.
// Assumes osc_inverter_input and fin are slow enough to sample on core_clk.
`timescale 1ns/1ps
module spsc_core
   import spsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire spsc_serial_t serial_in,
   input wire logic osc_inverter_input,
   input wire logic fin,
   output logic reference_compare_freq,
   output logic divided_vco_monitor,
   output logic modulus_ctrl,
   output logic lock_indicator,
   output logic pump_out,
   output logic pump_oe_n,
   output spsc_pump_t ext_pump
);
   typedef enum logic [1:0] {SPSC_IDLE, SPSC_UP, SPSC_DOWN} spsc_pfd_t;

   logic [SHIFT_W-1:0] shreg, next_shreg;
   logic [REF_W-1:0] ref_latch, next_ref_latch;
   logic [SWL_W-1:0] swl_latch, next_swl_latch;
   logic [MAIN_W-1:0] main_latch, next_main_latch;
   logic sclk_d, osc_d, fin_d, next_sclk_d, next_osc_d, next_fin_d;
   logic [REF_W-1:0] ref_cnt, next_ref_cnt;
   logic ref_tc, next_ref_tc;
   logic [MAIN_W-1:0] main_cnt, next_main_cnt;
   logic [SWL_W-1:0] swl_cnt, next_swl_cnt;
   logic main_tc, next_main_tc;
   logic mod_hi, next_mod_hi;
   spsc_pfd_t pfd, next_pfd;
   logic lock_q, next_lock_q;
   logic osc_rise, fin_fall;

   // Input edges found from the previous sample
   assign osc_rise = osc_inverter_input & ~osc_d;
   assign fin_fall = ~fin & fin_d;

   // Serial shift and latch transfer
   always_comb begin
      next_sclk_d = serial_in.sclk;
      next_shreg = shreg;
      next_ref_latch = ref_latch;
      next_swl_latch = swl_latch;
      next_main_latch = main_latch;
      if (serial_in.sclk && !sclk_d) begin
         next_shreg = {shreg[SHIFT_W-2:0], serial_in.data};
      end
      if (serial_in.load_en) begin
         if (shreg[0]) begin
            next_ref_latch = shreg[REF_W:1];
         end else begin
            // Earliest bits are most significant: swallow then main
            next_swl_latch = shreg[SHIFT_W-1 -: SWL_W];
            next_main_latch = shreg[MAIN_W:1];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_d <= 1'b0;
         shreg <= '0;
         ref_latch <= REF_RESET;
         swl_latch <= SWL_RESET;
         main_latch <= MAIN_RESET;
      end else begin
         sclk_d <= next_sclk_d;
         shreg <= next_shreg;
         ref_latch <= next_ref_latch;
         swl_latch <= next_swl_latch;
         main_latch <= next_main_latch;
      end
   end

   // Reference and main dividers with modulus control
   always_comb begin
      next_osc_d = osc_inverter_input;
      next_fin_d = fin;
      next_ref_cnt = ref_cnt;
      next_ref_tc = 1'b0;
      next_main_cnt = main_cnt;
      next_swl_cnt = swl_cnt;
      next_main_tc = 1'b0;
      next_mod_hi = mod_hi;
      if (osc_rise) begin
         if (ref_cnt <= REF_W'(1)) begin
            next_ref_cnt = ref_latch;
            next_ref_tc = 1'b1;
         end else begin
            next_ref_cnt = ref_cnt - REF_W'(1);
         end
      end
      if (fin_fall) begin
         // Swallow counter runs first with modulus low, then main finishes with it high
         if (swl_cnt != '0) begin
            next_swl_cnt = swl_cnt - SWL_W'(1);
            next_mod_hi = (swl_cnt == SWL_W'(1));
         end else begin
            next_mod_hi = 1'b1;
         end
         if (main_cnt <= MAIN_W'(1)) begin
            next_main_cnt = main_latch;
            next_swl_cnt = swl_latch;
            next_mod_hi = (swl_latch == '0);
            next_main_tc = 1'b1;
         end else begin
            next_main_cnt = main_cnt - MAIN_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         osc_d <= 1'b0;
         fin_d <= 1'b0;
         ref_cnt <= REF_RESET;
         ref_tc <= 1'b0;
         main_cnt <= MAIN_RESET;
         swl_cnt <= SWL_RESET;
         main_tc <= 1'b0;
         mod_hi <= 1'b1;
      end else begin
         osc_d <= next_osc_d;
         fin_d <= next_fin_d;
         ref_cnt <= next_ref_cnt;
         ref_tc <= next_ref_tc;
         main_cnt <= next_main_cnt;
         swl_cnt <= next_swl_cnt;
         main_tc <= next_main_tc;
         mod_hi <= next_mod_hi;
      end
   end

   // Phase/frequency detector: leading pulse sets, the other resets
   always_comb begin
      next_pfd = pfd;
      next_lock_q = 1'b1;
      unique case (pfd)
         SPSC_IDLE: begin
            if (ref_tc && !main_tc) next_pfd = SPSC_UP;
            else if (main_tc && !ref_tc) next_pfd = SPSC_DOWN;
         end
         SPSC_UP: begin
            if (main_tc) next_pfd = SPSC_IDLE;
            else if (ref_tc) next_pfd = SPSC_UP;
         end
         SPSC_DOWN: begin
            if (ref_tc) next_pfd = SPSC_IDLE;
         end
         default: next_pfd = SPSC_IDLE;
      endcase
      if (next_pfd != SPSC_IDLE) next_lock_q = 1'b0;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pfd <= SPSC_IDLE;
         lock_q <= 1'b1;
      end else begin
         pfd <= next_pfd;
         lock_q <= next_lock_q;
      end
   end

   // Output pins
   assign reference_compare_freq = ref_tc;
   assign divided_vco_monitor = main_tc;
   assign modulus_ctrl = mod_hi;
   assign lock_indicator = lock_q;
   assign pump_out = (pfd == SPSC_UP);
   assign pump_oe_n = (pfd == SPSC_IDLE);
   assign ext_pump.pump_up_n = (pfd != SPSC_UP);
   assign ext_pump.pump_down = (pfd == SPSC_DOWN);

   // Elaboration guard: the shared shift register must hold the main word and its control bit
   if (SHIFT_W != MAINWORD_W + 1 || SHIFT_W < REF_W + 1) begin : g_width_guard
      $error("shift register width does not fit the serial words");
   end
   // Elaboration guard: reset divide factors must not fall below the legal minimum of five
   if (REF_RESET < REF_W'(5) || MAIN_RESET < MAIN_W'(5)) begin : g_reset_guard
      $error("reset divide factor below five");
   end

   // Checks: each one guards a rule of the serial load, dividers or detector
   // Reference latch takes the shifted word while load is high and control is set
   load_ref_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      serial_in.load_en && shreg[0] |=> ref_latch == $past(shreg[REF_W:1]))
      else $error("ref latch not loaded");

   // Main latch takes swallow and main fields while load is high and control is clear
   load_main_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      serial_in.load_en && !shreg[0] |=> main_latch == $past(shreg[MAIN_W:1])
      && swl_latch == $past(shreg[SHIFT_W-1 -: SWL_W]))
      else $error("main latch not loaded");

   // Latches keep their value while load enable is low
   latch_hold_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !serial_in.load_en |=> $stable(ref_latch) && $stable(swl_latch) && $stable(main_latch))
      else $error("latch changed without load");

   // A rising shift clock takes exactly the data bit that stood before it
   shift_bit_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      serial_in.sclk && !sclk_d |=> shreg[0] == $past(serial_in.data))
      else $error("bit not shifted");

   // Without a rising shift clock the shift register holds still
   shift_hold_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !(serial_in.sclk && !sclk_d) |=> $stable(shreg))
      else $error("shift without clock edge");

   // Reference counter reloads from the latch at its terminal count and pulses
   ref_wrap_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      osc_rise && ref_cnt <= REF_W'(1) |=> ref_tc && ref_cnt == $past(ref_latch))
      else $error("ref counter wrap");

   // Reference pulse lasts a single cycle
   ref_pulse_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      reference_compare_freq |=> !reference_compare_freq)
      else $error("ref pulse too long");

   // Main counter reloads the swallow count from its latch at its terminal count and pulses the monitor
   main_wrap_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      fin_fall && main_cnt <= MAIN_W'(1) |=> divided_vco_monitor && swl_cnt == $past(swl_latch))
      else $error("main counter wrap");

   // Monitor pulse lasts a single cycle
   vco_pulse_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      divided_vco_monitor |=> !divided_vco_monitor)
      else $error("monitor pulse too long");

   // Modulus output moves only after a falling divider clock
   mod_edge_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !fin_fall |=> $stable(modulus_ctrl))
      else $error("modulus moved off fin fall");

   // A nonzero swallow count starts the cycle in the higher modulus
   mod_low_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      fin_fall && main_cnt <= MAIN_W'(1) && swl_latch != '0 |=> !modulus_ctrl)
      else $error("modulus not low after wrap");

   // Last swallowed output returns the prescaler to the lower modulus
   swl_done_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      fin_fall && main_cnt > MAIN_W'(1) && swl_cnt == SWL_W'(1) |=> modulus_ctrl)
      else $error("modulus not high after swallow");

   // Idle detector floats the pump and shows lock
   pump_float_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      pfd == SPSC_IDLE |-> pump_oe_n && lock_indicator)
      else $error("pump not floating");

   // A leading reference pulse makes the pump drive high
   detect_up_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      pfd == SPSC_IDLE && ref_tc && !main_tc |=> pump_out && !pump_oe_n)
      else $error("pump not driving high");

   // A leading divided pulse makes the pump sink
   detect_down_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      pfd == SPSC_IDLE && main_tc && !ref_tc |=> !pump_out && !pump_oe_n)
      else $error("pump not sinking");

   // External up signal follows the on-chip pump drive
   pump_ext_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      pump_out |-> !ext_pump.pump_up_n && !pump_oe_n)
      else $error("external pump mismatch");

   // External down signal follows the on-chip pump sink
   pump_down_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      pfd == SPSC_DOWN |-> ext_pump.pump_down && ext_pump.pump_up_n && !pump_out)
      else $error("external down mismatch");

   // Lock output is low while the detector is active
   lock_low_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      pfd != SPSC_IDLE |-> !lock_indicator)
      else $error("lock high while unlocked");

   // Main scenarios: both detector directions, both latch loads, swallow phase ending
   cov_up_c: cover property (
      @(posedge core_clk) pfd == SPSC_UP);
   cov_down_c: cover property (
      @(posedge core_clk) pfd == SPSC_DOWN);
   cov_load_c: cover property (
      @(posedge core_clk) serial_in.load_en && shreg[0]);
   cov_main_load_c: cover property (
      @(posedge core_clk) serial_in.load_en && !shreg[0]);
   cov_swallow_c: cover property (
      @(posedge core_clk) disable iff (!rstn) $rose(modulus_ctrl));
endmodule

// file: test/spsc_host_model.sv
// Host controller model that loads divide words over the three-wire serial port.
// Assumes core_clk is the core's clock; pins change 2 ns after its rising edge.
`timescale 1ns/1ps
module spsc_host_model
   import spsc_pkg::*;
(
   input wire logic core_clk,
   output spsc_serial_t serial_out
);
   initial serial_out = '0;
   // Shifts nbits of word, MSB first with the steering bit last, then pulses load enable
   task automatic send(input logic [SHIFT_W-1:0] word, input int nbits);
      for (int i = nbits - 1; i >= 0; i--) begin
         @(posedge core_clk) #2;
         serial_out.data = word[i];
         @(posedge core_clk) #2;
         serial_out.sclk = 1'b1;
         @(posedge core_clk) #2;
         serial_out.sclk = 1'b0;
         serial_out.data = ~word[i]; // Hold time over, line no longer valid
      end
      @(posedge core_clk) #2;
      serial_out.load_en = 1'b1;
      @(posedge core_clk) #2;
      serial_out.load_en = 1'b0;
   endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the synthesizer core: serial loads, divider periods, pump.
// Assumes the host model drives the serial pins; osc and fin are made here.
`timescale 1ns/1ps
module testbench;
   import spsc_pkg::*;
   logic core_clk, rstn, osc_inverter_input, fin, reference_compare_freq, divided_vco_monitor;
   logic modulus_ctrl, lock_indicator, pump_out, pump_oe_n;
   spsc_serial_t serial_in;
   spsc_pump_t ext_pump;
   int mismatches, samples_checked, cycles, osc_cnt, fin_cnt, fin_half, n;
   spsc_core i_dut (.core_clk(core_clk), .rstn(rstn), .serial_in(serial_in),
      .osc_inverter_input(osc_inverter_input), .fin(fin), .reference_compare_freq(reference_compare_freq),
      .divided_vco_monitor(divided_vco_monitor), .modulus_ctrl(modulus_ctrl), .lock_indicator(lock_indicator),
      .pump_out(pump_out), .pump_oe_n(pump_oe_n), .ext_pump(ext_pump));
   spsc_host_model i_host (.core_clk(core_clk), .serial_out(serial_in));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Oscillator toggles every 2 cycles, fin every fin_half cycles; also the hang limit
   always @(posedge core_clk) begin
      #2;
      cycles++;
      osc_cnt++;
      fin_cnt++;
      if (osc_cnt >= 2) begin osc_cnt = 0; osc_inverter_input = ~osc_inverter_input; end
      if (fin_cnt >= fin_half) begin fin_cnt = 0; fin = ~fin; end
      if (cycles == 40000) begin mismatches++; end_of_test(); end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   function automatic logic pick(input int sel);
      return sel == 0 ? reference_compare_freq : divided_vco_monitor;
   endfunction
   // Cycles between two pulses; low counts modulus_ctrl low cycles in between
   task automatic gap(input int sel, output int len, output int low);
      int k;
      len = 0; low = 0; k = 0;
      while (pick(sel) !== 1'b1 && k < 3000) begin @(negedge core_clk); k++; end
      // The pulse cycle itself already shows the modulus of the new cycle
      if (modulus_ctrl === 1'b0) low++;
      @(negedge core_clk);
      while (pick(sel) !== 1'b1 && k < 3000) begin
         if (modulus_ctrl === 1'b0) low++;
         @(negedge core_clk);
         k++;
         len++;
      end
      len++;
      // Pulse wait limit run out counts as a mismatch
      if (k >= 3000) mismatches++;
   endtask
   // Reference word: period follows R osc edges at 4 cycles each
   task automatic ref_divide(input int r);
      int low;
      i_host.send({4'h0, r[13:0]} << 1 | 18'h00001, 15);
      gap(0, n, low);
      gap(0, n, low);
      check("ref period", n, r * 4);
   endtask
   // Main word: monitor period N fin periods, modulus low for A of them
   task automatic main_divide(input int a, input int nn);
      int low;
      i_host.send({a[6:0], nn[9:0], 1'b0}, 18);
      gap(1, n, low);
      gap(1, n, low);
      check("vco period", n, nn * 4);
      check("modulus low", low, a * 4);
   endtask
   // Detector drive direction with one side faster; lock drops meanwhile
   task automatic pump_dir(input int half, input logic up);
      int drv, lck, ext;
      drv = 0; lck = 0; ext = 0;
      fin_half = half;
      repeat (300) begin
         @(negedge core_clk);
         if (pump_oe_n === 1'b0 && pump_out === up) drv = 1;
         if (lock_indicator === 1'b0) lck = 1;
         if ((up ? ~ext_pump.pump_up_n : ext_pump.pump_down) === 1'b1) ext = 1;
      end
      check("pump drive", drv, 1);
      check("lock pulse", lck, 1);
      check("ext pump", ext, 1);
   endtask
   task automatic end_of_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Outputs right after reset: detector idle, lock high, lower modulus selected
   task automatic reset_state();
      @(negedge core_clk);
      check("lock after reset", lock_indicator, 1);
      check("pump float after reset", pump_oe_n, 1);
      check("modulus after reset", modulus_ctrl, 1);
   endtask
   // Main sequence
   initial begin
      rstn = 1'b0;
      osc_inverter_input = 1'b0;
      fin = 1'b0;
      fin_half = 2;
      repeat (12) @(posedge core_clk);
      #2 rstn = 1'b1;
      reset_state();
      ref_divide(7);
      ref_divide(5);
      main_divide(2, 6);
      main_divide(0, 5);
      main_divide(4, 9);
      pump_dir(3, 1'b1);
      pump_dir(1, 1'b0);
      end_of_test();
   end
endmodule
